// ---- hdl/remote_select.sv ----
// remote interface selection, bus address match and serial port with flow control
`timescale 1ns/10ps
`default_nettype none
module remote_select
    import remote_select_pkg::*;
#(
    parameter int unsigned DIV_1200 = CLK_HZ / RATE_1200,
    parameter int unsigned DIV_2400 = CLK_HZ / RATE_2400,
    parameter int unsigned DIV_4800 = CLK_HZ / RATE_4800,
    parameter int unsigned DIV_9600 = CLK_HZ / RATE_9600
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire cfg_s cfg_in,
    output cfg_s cfg_out,
    output logic cfg_bad,
    output logic bus_en,
    input wire logic [4:0] bus_addr_in,
    output logic bus_addr_hit,
    output logic ser_en,
    output logic txd,
    input wire logic rxd,
    output logic rts_n,
    input wire logic cts_n,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    output logic rx_frame_err
);
    state_s s_reg;
    state_s s_next;
    logic [DIV_W-1:0] div_sel;
    logic ser_on;
    logic paused;
    logic send_xoff;
    logic send_xon;
    logic push;
    logic pop;

    always_comb begin
        unique case (s_reg.cfg.baud)
            BAUD_1200: div_sel = DIV_W'(DIV_1200 - 1);
            BAUD_2400: div_sel = DIV_W'(DIV_2400 - 1);
            BAUD_4800: div_sel = DIV_W'(DIV_4800 - 1);
            BAUD_9600: div_sel = DIV_W'(DIV_9600 - 1);
        endcase
    end

    assign ser_on = (s_reg.cfg.iface == IF_SERIAL); // [RL1] [RL3]
    // peer pause source follows the handshake mode only
    assign paused = (s_reg.cfg.hs == HS_RTS) ? cts_n : s_reg.peer_paused; // [RL6] [RL7] [RL9]
    assign send_xoff = ser_on && s_reg.cfg.hs == HS_XON && !s_reg.xoff_sent
        && s_reg.cnt >= FIFO_HIGH; // [RL11]
    assign send_xon = ser_on && s_reg.cfg.hs == HS_XON && s_reg.xoff_sent
        && s_reg.cnt <= FIFO_LOW; // [RL11]
    // flow-control characters go out ahead of user data
    assign tx_ready = ser_on && !s_reg.tx_busy && !send_xoff && !send_xon && !paused;
    assign rx_valid = (s_reg.cnt != 3'h0);
    assign rx_data = s_reg.fifo[s_reg.rp];
    assign pop = rx_valid && rx_ready;

    always_comb begin
        s_next = s_reg;
        push = 1'b0;
        s_next.cfg_bad = 1'b0;
        s_next.rx_overrun = 1'b0;
        s_next.rx_frame_err = 1'b0;
        // settings change only on an explicit write or on rst, which loads CFG_DEFAULT
        if (cfg_wr) begin // [RL10]
            if (cfg_in.addr > ADDR_MAX) begin
                s_next.cfg_bad = 1'b1; // [RL4]
            end else begin
                s_next.cfg = cfg_in;
            end
        end
        // transmitter: start, 8 data, stop, lsb first
        if (!s_reg.tx_busy) begin
            if (send_xoff || send_xon || (tx_valid && tx_ready)) begin
                s_next.tx_busy = 1'b1;
                s_next.txd = 1'b0; // [RL8]
                s_next.tx_left = FRAME_BITS - 4'h1;
                s_next.tx_cnt = div_sel; // [RL5]
                s_next.tx_sh = {1'b1, send_xoff ? XOFF_CHAR : (send_xon ? XON_CHAR : tx_data)};
                s_next.xoff_sent = send_xoff ? 1'b1 : (send_xon ? 1'b0 : s_reg.xoff_sent);
            end
        end else if (s_reg.tx_cnt != '0) begin
            s_next.tx_cnt = s_reg.tx_cnt - DIV_W'(1);
        end else if (s_reg.tx_left == 4'h0) begin
            s_next.tx_busy = 1'b0;
            s_next.txd = 1'b1;
        end else begin
            s_next.txd = s_reg.tx_sh[0];
            s_next.tx_sh = {1'b1, s_reg.tx_sh[8:1]};
            s_next.tx_left = s_reg.tx_left - 4'h1;
            s_next.tx_cnt = div_sel;
        end
        // receiver samples each bit in its middle
        unique case (s_reg.rx_st)
            RX_IDLE: begin
                if (ser_on && !rxd) begin
                    s_next.rx_st = RX_START;
                    s_next.rx_cnt = div_sel >> 1;
                end
            end
            RX_START: begin
                if (s_reg.rx_cnt != '0) begin
                    s_next.rx_cnt = s_reg.rx_cnt - DIV_W'(1);
                end else if (rxd) begin
                    s_next.rx_st = RX_IDLE;
                end else begin
                    s_next.rx_st = RX_DATA;
                    s_next.rx_cnt = div_sel;
                    s_next.rx_bit = 3'h0;
                end
            end
            RX_DATA: begin
                if (s_reg.rx_cnt != '0) begin
                    s_next.rx_cnt = s_reg.rx_cnt - DIV_W'(1);
                end else begin
                    s_next.rx_sh = {rxd, s_reg.rx_sh[7:1]};
                    s_next.rx_cnt = div_sel;
                    s_next.rx_bit = s_reg.rx_bit + 3'h1;
                    if (s_reg.rx_bit == DATA_LAST) begin
                        s_next.rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (s_reg.rx_cnt != '0) begin
                    s_next.rx_cnt = s_reg.rx_cnt - DIV_W'(1);
                end else begin
                    s_next.rx_st = RX_IDLE;
                    if (!rxd) begin
                        s_next.rx_frame_err = 1'b1; // [RL8]
                    end else if (s_reg.cfg.hs == HS_XON && s_reg.rx_sh == XOFF_CHAR) begin
                        s_next.peer_paused = 1'b1; // [RL6]
                    end else if (s_reg.cfg.hs == HS_XON && s_reg.rx_sh == XON_CHAR) begin
                        s_next.peer_paused = 1'b0; // [RL6]
                    end else if (s_reg.cnt == FIFO_FULL && !pop) begin
                        s_next.rx_overrun = 1'b1;
                    end else begin
                        push = 1'b1;
                    end
                end
            end
        endcase
        if (push) begin
            s_next.fifo[s_reg.wp] = s_reg.rx_sh;
            s_next.wp = s_reg.wp + 2'h1;
        end
        if (pop) begin
            s_next.rp = s_reg.rp + 2'h1;
        end
        s_next.cnt = s_reg.cnt + {2'h0, push} - {2'h0, pop};
        if (s_reg.cfg.hs != HS_XON) begin
            s_next.xoff_sent = 1'b0; // [RL9]
            s_next.peer_paused = 1'b0;
        end
        // leaving the serial port drops half-done traffic at once, so off is silent at once
        if (s_next.cfg.iface != IF_SERIAL) begin // [RL3]
            s_next.tx_busy = 1'b0;
            s_next.txd = 1'b1;
            s_next.rx_st = RX_IDLE;
            s_next.cnt = 3'h0;
            s_next.rp = s_next.wp;
            s_next.xoff_sent = 1'b0;
            s_next.peer_paused = 1'b0;
        end
        // rts only carries readiness in hardware mode, held asserted in software mode, deasserted when serial is not selected
        if (s_next.cfg.iface != IF_SERIAL) begin
            s_next.rts_n = 1'b1;
        end else if (s_next.cfg.hs == HS_RTS) begin
            s_next.rts_n = (s_next.cnt >= FIFO_HIGH); // [RL7] [RL9]
        end else begin
            s_next.rts_n = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{cfg: CFG_DEFAULT, txd: 1'b1, rts_n: 1'b1, tx_sh: 9'h1FF,
                       rx_st: RX_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg_out = s_reg.cfg;
    assign cfg_bad = s_reg.cfg_bad;
    assign bus_en = (s_reg.cfg.iface == IF_BUS); // [RL1] [RL2]
    assign bus_addr_hit = bus_en && (bus_addr_in == s_reg.cfg.addr); // [RL4]
    assign ser_en = ser_on;
    assign txd = s_reg.txd;
    assign rts_n = s_reg.rts_n;
    assign rx_overrun = s_reg.rx_overrun;
    assign rx_frame_err = s_reg.rx_frame_err;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_single_iface: assert property (!(bus_en && ser_en)) // [RL1]
        else $error("both remote interfaces active");
    a_bus_select: assert property (cfg_wr && cfg_in.iface == IF_BUS // [RL2]
        && cfg_in.addr <= ADDR_MAX |=> bus_en && !ser_en)
        else $error("bus not enabled after selection");
    a_off_silent: assert property (cfg_out.iface == IF_OFF |-> txd && rts_n // [RL3]
        && !rx_valid && !tx_ready && !bus_addr_hit)
        else $error("traffic while interfaces off");
    a_addr_range: assert property (cfg_wr && cfg_in.addr > ADDR_MAX // [RL4]
        |=> cfg_bad && $stable(cfg_out))
        else $error("out of range bus address accepted");
    // a rate change mid-frame is legal, so the timer is checked where it is loaded
    a_div_bound: assert property ($rose(s_reg.tx_busy) // [RL5]
        |-> s_reg.tx_cnt == $past(div_sel))
        else $error("bit timer not loaded from selected rate");
    a_peer_pause: assert property (cfg_out.hs == HS_XON && s_reg.peer_paused // [RL6]
        |-> !tx_ready)
        else $error("sent while partner paused");
    a_cts_hold: assert property (ser_en && cfg_out.hs == HS_RTS && cts_n |-> !tx_ready) // [RL7]
        else $error("sent while cts deasserted");
    a_frame_edges: assert property ($rose(s_reg.tx_busy) |-> !txd ##0 // [RL8]
        (!$fell(s_reg.tx_busy) && s_reg.tx_left == FRAME_BITS - 4'h1))
        else $error("frame does not open with start bit");
    a_stop_level: assert property ($fell(s_reg.tx_busy) && ser_en |-> txd) // [RL8]
        else $error("frame does not end at idle");
    a_rts_only: assert property (ser_en && cfg_out.hs == HS_XON |-> !rts_n) // [RL9]
        else $error("rts toggled in software mode");
    a_cfg_hold: assert property (!cfg_wr |=> $stable(cfg_out)) // [RL10]
        else $error("settings changed without write");
    // a write in the same cycle may switch the port away and drop the frame
    a_xoff_send: assert property (send_xoff && !s_reg.tx_busy && !cfg_wr // [RL11]
        |=> s_reg.tx_busy && s_reg.xoff_sent && s_reg.tx_sh[7:0] == XOFF_CHAR)
        else $error("xoff not sent near full");
endmodule
`default_nettype wire

// ---- hdl/remote_select_pkg.sv ----
// constants and types for the remote interface selector and serial port
// Contract
// RL1: Only one remote interface, parallel bus or serial, is active at a time.
// RL2: Selecting the parallel bus turns on the built-in instrument bus interface.
// RL3: Selecting off disables both interfaces so that no remote traffic is taken.
// RL4: The bus address lies in 0 to 30, defaults to 12, and only that address is answered.
// RL5: The serial bit rate is one of 1200, 2400, 4800 or 9600, default 9600, same on both ends.
// RL6: In software flow control XON and XOFF signal readiness, default mode, and the partner obeys.
// RL7: In hardware flow control RTS and CTS signal readiness and the partner obeys them.
// RL8: Each character is one start bit, eight data bits, one stop bit and no parity.
// RL9: The chosen handshake mode is the only way readiness to receive is signalled.
// RL10: Interface, address, bit rate and handshake are kept until changed, not reset by preset.
// RL11: In software mode XOFF is sent when the receive buffer nears full and XON when space frees.
package remote_select_pkg;
    typedef enum logic [1:0] {IF_BUS, IF_SERIAL, IF_OFF} iface_e;
    typedef enum logic [1:0] {BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600} baud_e;
    typedef enum logic {HS_XON, HS_RTS} hs_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_e;

    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned RATE_1200 = 1200;
    localparam int unsigned RATE_2400 = 2400;
    localparam int unsigned RATE_4800 = 4800;
    localparam int unsigned RATE_9600 = 9600;
    localparam int DIV_W = 18;
    localparam logic [4:0] ADDR_MAX = 5'h1E;
    localparam logic [4:0] ADDR_DEFAULT = 5'h0C;
    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam logic [2:0] DATA_LAST = 3'h7;
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam int FIFO_DEPTH = 4;
    localparam logic [2:0] FIFO_FULL = 3'h4;
    localparam logic [2:0] FIFO_HIGH = 3'h3;
    localparam logic [2:0] FIFO_LOW = 3'h1;

    typedef struct packed {
        iface_e iface;
        logic [4:0] addr;
        baud_e baud;
        hs_e hs;
    } cfg_s;

    localparam cfg_s CFG_DEFAULT = '{iface: IF_BUS, addr: ADDR_DEFAULT, baud: BAUD_9600,
                                     hs: HS_XON};

    typedef struct packed {
        cfg_s cfg;
        logic cfg_bad;
        logic txd;
        logic rts_n;
        logic tx_busy;
        logic [DIV_W-1:0] tx_cnt;
        logic [3:0] tx_left;
        logic [8:0] tx_sh;
        logic xoff_sent;
        logic peer_paused;
        rx_e rx_st;
        logic [DIV_W-1:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_overrun;
        logic rx_frame_err;
        logic [FIFO_DEPTH-1:0][7:0] fifo;
        logic [1:0] wp;
        logic [1:0] rp;
        logic [2:0] cnt;
    } state_s;
endpackage

// ---- sim/serial_host.sv ----
// far-end host model: serial frame sender and receiver
`timescale 1ns/10ps
`default_nettype none
module serial_host (
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    input wire logic [7:0] div,
    output logic [7:0] got,
    output logic got_ok,
    output logic [7:0] n_got
);
    logic [7:0] sh;
    initial begin
        rxd = 1'b1;
        n_got = 8'h00;
    end
    // start, d0..d7 lsb first, stop, no parity; div cycles a bit
    // line returns to idle after the frame, even when the stop bit was forced low
    task automatic send_frame(input logic [9:0] f);
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            rxd = f[i];
            repeat (div - 1) @(negedge clk);
        end
        @(negedge clk);
        rxd = 1'b1;
    endtask
    task automatic send(input logic [7:0] b);
        send_frame({1'b1, b, 1'b0});
    endtask
    // mid-bit sampling: a wrong rate shows as corrupt data
    always begin
        @(negedge txd);
        repeat (div / 2) @(posedge clk);
        got_ok = (txd === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk);
            sh[i] = txd;
        end
        repeat (div) @(posedge clk);
        got = sh;
        got_ok = got_ok && (txd === 1'b1);
        n_got = n_got + 8'h01;
    end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the remote interface selector
`timescale 1ns/10ps
`default_nettype none
module tb
    import remote_select_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_wr = 1'b0;
    cfg_s cfg_in = CFG_DEFAULT;
    cfg_s cfg_out;
    logic cfg_bad, bus_en, hit, ser_en, txd, rxd, rts_n, tx_ready, rx_valid, got_ok, bad;
    logic ovr, ferr;
    logic [4:0] addr = 5'h00;
    logic cts_n = 1'b0;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data, got, n_got, n;
    logic [7:0] div = 8'h08;
    logic [7:0] divs [4] = '{8'h40, 8'h20, 8'h10, 8'h08};
    int failures = 0;
    int checked = 0;
    int n_ovr = 0;
    int n_ferr = 0;
    always #2.5 clk = ~clk;
    // error pulses last one cycle, so count them as they pass
    always @(posedge clk) begin
        if (ovr === 1'b1) begin
            n_ovr <= n_ovr + 1;
        end
        if (ferr === 1'b1) begin
            n_ferr <= n_ferr + 1;
        end
    end
    // small dividers keep frames short, ratios kept 8:4:2:1
    remote_select #(.DIV_1200(64), .DIV_2400(32), .DIV_4800(16), .DIV_9600(8)) i_dut (
        .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .cfg_out(cfg_out),
        .cfg_bad(cfg_bad), .bus_en(bus_en), .bus_addr_in(addr), .bus_addr_hit(hit),
        .ser_en(ser_en), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(ovr), .rx_frame_err(ferr));
    serial_host i_host (.clk(clk), .txd(txd), .rxd(rxd), .div(div), .got(got),
        .got_ok(got_ok), .n_got(n_got));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic set_cfg(input iface_e f, input logic [4:0] a, input baud_e b, input hs_e h);
        @(negedge clk);
        cfg_in = '{iface: f, addr: a, baud: b, hs: h};
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        bad = cfg_bad;
    endtask
    task automatic wait_got(input logic [7:0] c);
        int k;
        for (k = 0; k < 3000 && n_got !== c; k++) @(posedge clk);
        if (k == 3000) begin
            failures++;
            test_done();
        end
    endtask
    // request held from a falling edge until ready is seen high
    task automatic send_tx(input logic [7:0] b);
        int k;
        @(negedge clk);
        tx_data = b;
        tx_valid = 1'b1;
        for (k = 0; k < 3000 && tx_ready !== 1'b1; k++) @(negedge clk);
        if (k == 3000) begin
            failures++;
            test_done();
        end
        @(negedge clk);
        tx_valid = 1'b0;
    endtask
    task automatic pop(input logic [7:0] e);
        @(negedge clk);
        check(rx_valid, 1);
        check(rx_data, e);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask
    task automatic t_select();
        check(cfg_out, CFG_DEFAULT);
        check({bus_en, ser_en, txd}, 3'h5);
        addr = ADDR_DEFAULT;
        #1 check(hit, 1);
        @(negedge clk);
        addr = 5'h0D;
        #1 check(hit, 0);
        set_cfg(IF_BUS, 5'h1F, BAUD_1200, HS_RTS);
        check(bad, 1);
        check(cfg_out, CFG_DEFAULT);
        set_cfg(IF_BUS, ADDR_MAX, BAUD_9600, HS_XON);
        addr = ADDR_MAX;
        #1 check({bad, hit}, 2'h1);
        set_cfg(IF_OFF, ADDR_MAX, BAUD_9600, HS_XON);
        check({bus_en, ser_en, hit, rts_n, txd}, 5'h3);
        set_cfg(IF_SERIAL, ADDR_MAX, BAUD_9600, HS_XON);
        check({bus_en, ser_en, hit}, 3'h2);
    endtask
    task automatic t_rates();
        for (int k = 0; k < 4; k++) begin
            set_cfg(IF_SERIAL, ADDR_DEFAULT, baud_e'(k[1:0]), HS_XON);
            div = divs[k];
            n = n_got;
            send_tx(8'h5A ^ k[7:0]);
            wait_got(n + 8'h01);
            check({got_ok, got}, {1'b1, 8'h5A ^ k[7:0]});
        end
    endtask
    task automatic t_rts();
        set_cfg(IF_SERIAL, ADDR_DEFAULT, BAUD_9600, HS_RTS);
        n = n_got;
        check(rts_n, 0);
        // host sends only while ready is shown low
        for (int k = 0; k < 3; k++) begin
            check(rts_n, 0);
            i_host.send(8'hC0 + k[7:0]);
        end
        check(rts_n, 1);
        cts_n = 1'b1;
        tx_valid = 1'b1;
        repeat (30) @(negedge clk);
        check({tx_ready, n_got}, {1'b0, n});
        tx_valid = 1'b0;
        cts_n = 1'b0;
        for (int k = 0; k < 3; k++) pop(8'hC0 + k[7:0]);
        check(rts_n, 0);
    endtask
    task automatic t_xon();
        set_cfg(IF_SERIAL, ADDR_DEFAULT, BAUD_9600, HS_XON);
        n = n_got;
        for (int k = 0; k < 3; k++) i_host.send(8'hA0 + k[7:0]);
        wait_got(n + 8'h01);
        check(got, XOFF_CHAR);
        pop(8'hA0);
        pop(8'hA1);
        wait_got(n + 8'h02);
        check({got, rts_n}, {XON_CHAR, 1'b0});
        pop(8'hA2);
        i_host.send(XOFF_CHAR);
        tx_valid = 1'b1;
        repeat (30) @(negedge clk);
        check({tx_ready, rx_valid}, 2'h0);
        tx_valid = 1'b0;
        i_host.send(XON_CHAR);
        send_tx(8'h77);
        wait_got(n + 8'h03);
        check({got, rx_valid}, {8'h77, 1'b0});
    endtask
    task automatic t_errors();
        set_cfg(IF_SERIAL, ADDR_DEFAULT, BAUD_9600, HS_RTS);
        // host ignores ready on purpose: the fifth char finds the fifo full
        for (int k = 0; k < 5; k++) i_host.send(8'hE0 + k[7:0]);
        check(n_ovr, 1);
        i_host.send_frame({1'b0, 8'h3C, 1'b0});
        check(n_ferr, 1);
        for (int k = 0; k < 4; k++) pop(8'hE0 + k[7:0]);
        check({rx_valid, rts_n}, 2'h0);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_select();
        t_rates();
        t_rts();
        t_xon();
        t_errors();
        test_done();
    end
endmodule
`default_nettype wire
